/* File: rtl/hbdd_pkg.sv */
`default_nettype none
package hbdd_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int DEAD_NS_0 = 1000;
	localparam int DEAD_NS_1 = 2000;
	localparam int DEAD_NS_2 = 4000;
	localparam int DEAD_NS_3 = 8000;
	localparam logic [9:0] DEAD_CYC_0 = 10'((DEAD_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [9:0] DEAD_CYC_1 = 10'((DEAD_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [9:0] DEAD_CYC_2 = 10'((DEAD_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [9:0] DEAD_CYC_3 = 10'((DEAD_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [9:0] CNT_MAX = 10'h3ff;

	// ==========================================================
	// register map
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_CHANNEL = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam int BR1_SEL_BIT = 0;
	localparam int BR2_SEL_BIT = 1;
	localparam int AFW1_BIT = 2;
	localparam int AFW2_BIT = 3;
	localparam int DT1_LSB = 4;
	localparam int DT2_LSB = 6;
	localparam int FET_LSB = 8;
	localparam int OUTEN_LSB = 16;
	localparam int SPI_ON_LSB = 0;
	localparam int INSEL_LSB = 8;
	localparam int ST_GATE_LSB = 0;
	localparam int ST_PIN_LSB = 8;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_00f0;
	localparam logic [31:0] CONFIG_MASK = 32'h00ff_ffff;
	localparam logic [31:0] CHANNEL_RESET = 32'h0000_0000;
	localparam logic [31:0] CHANNEL_MASK = 32'h0000_ffff;

	// ==========================================================
	// bridge roles and switch patterns, bit 0 = Q1 .. bit 3 = Q4
	localparam int PIN_PWM = 0;
	localparam int PIN_DIR = 1;
	localparam int PIN_FLOAT = 2;
	localparam int HS_COUNT = 2;
	localparam logic [3:0] Q_OFF = 4'h0;
	localparam logic [3:0] Q_FWD = 4'h9;
	localparam logic [3:0] Q_REV = 4'h6;
	localparam logic [3:0] Q_FW_FWD = 4'h8;
	localparam logic [3:0] Q_FW_REV = 4'h4;
	localparam logic [3:0] Q_BRAKE = 4'hc;

	// ==========================================================
	// synchronised pins
	typedef struct packed {
		logic disable_pin_n;
		logic disable_pin;
		logic channel_six_enable_pin;
		logic [7:0] channel_control_pin_n;
	} hbdd_pins_type;
	localparam int PINS_W = 11;
	localparam logic [10:0] PINS_RESET = 11'h2ff;
	localparam int CH6_INDEX = 5;

endpackage
`default_nettype wire

/* File: rtl/hbdd_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module hbdd_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic pclk, // clock
	input wire logic rst_n, // async reset, low
	input wire logic [W-1:0] d, // asynchronous input
	output logic [W-1:0] q // synchronised output
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	if (W < 1) begin : g_chk
		$error("hbdd_sync width must be at least one");
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= RESET_VAL;
			sync_reg <= RESET_VAL;
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;
endmodule // hbdd_sync
`default_nettype wire

/* File: rtl/hbdd_bridge.sv */
`timescale 1ns/1ns
`default_nettype none
module hbdd_bridge (
	input wire logic pclk, // clock
	input wire logic rst_n, // async reset, low
	input wire logic active, // bridge selected
	input wire logic kill, // disable pins asserted
	input wire logic afw, // active freewheel enable
	input wire logic [1:0] dead_sel, // dead time select
	input wire logic pwm_drive_n, // pwm, low = drive
	input wire logic dir, // direction
	input wire logic float_request, // float request
	output logic [3:0] q // switch commands Q1..Q4
);
	logic [3:0] target;
	logic [3:0] tgt_prev_reg;
	logic [3:0] q_reg;
	logic [9:0] cnt_reg;
	logic [9:0] dead_cyc;
	logic changed;
	logic settled;
	logic go;

	assign go = active && !kill && !float_request;

	// ==========================================================
	// truth table
	always_comb begin
		if (!go) begin
			target = hbdd_pkg::Q_OFF;
		end else if (!pwm_drive_n) begin
			target = dir ? hbdd_pkg::Q_FWD : hbdd_pkg::Q_REV;
		end else if (afw) begin
			target = hbdd_pkg::Q_BRAKE;
		end else begin
			target = dir ? hbdd_pkg::Q_FW_FWD : hbdd_pkg::Q_FW_REV;
		end
	end

	// ==========================================================
	// dead time: off at once, on only after the target has held
	always_comb begin
		unique case (dead_sel)
			2'h0: dead_cyc = hbdd_pkg::DEAD_CYC_0;
			2'h1: dead_cyc = hbdd_pkg::DEAD_CYC_1;
			2'h2: dead_cyc = hbdd_pkg::DEAD_CYC_2;
			2'h3: dead_cyc = hbdd_pkg::DEAD_CYC_3;
		endcase
	end

	assign changed = target != tgt_prev_reg;
	assign settled = !changed && (cnt_reg >= dead_cyc);

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			tgt_prev_reg <= hbdd_pkg::Q_OFF;
		end else begin
			tgt_prev_reg <= target;
		end
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (changed) begin
			cnt_reg <= '0;
		end else if (cnt_reg != hbdd_pkg::CNT_MAX) begin
			cnt_reg <= cnt_reg + 10'h001;
		end
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			q_reg <= hbdd_pkg::Q_OFF;
		end else begin
			q_reg <= target & (q_reg | {4{settled}});
		end
	end

	assign q = q_reg;

	// ==========================================================
	// checks
	sequence s_fwd;
		go && dir && !pwm_drive_n && settled;
	endsequence
	sequence s_rev;
		go && !dir && !pwm_drive_n && settled;
	endsequence
	sequence s_coast;
		go && pwm_drive_n && settled;
	endsequence

	a_forward_drive: assert property (@(posedge pclk) disable iff (!rst_n)
		s_fwd |=> q == hbdd_pkg::Q_FWD)
		else $error("forward pattern wrong");
	a_reverse_drive: assert property (@(posedge pclk) disable iff (!rst_n)
		s_rev |=> q == hbdd_pkg::Q_REV)
		else $error("reverse pattern wrong");
	a_freewheel_fwd: assert property (@(posedge pclk) disable iff (!rst_n)
		(s_coast and (dir && !afw)) |=> q == hbdd_pkg::Q_FW_FWD)
		else $error("forward freewheel wrong");
	a_freewheel_rev: assert property (@(posedge pclk) disable iff (!rst_n)
		(s_coast and (!dir && !afw)) |=> q == hbdd_pkg::Q_FW_REV)
		else $error("reverse freewheel wrong");
	a_brake_fwd: assert property (@(posedge pclk) disable iff (!rst_n)
		(s_coast and (dir && afw)) |=> q == hbdd_pkg::Q_BRAKE)
		else $error("forward brake wrong");
	a_brake_rev: assert property (@(posedge pclk) disable iff (!rst_n)
		(s_coast and (!dir && afw)) |=> q == hbdd_pkg::Q_BRAKE)
		else $error("reverse brake wrong");
	a_float_all_off: assert property (@(posedge pclk) disable iff (!rst_n)
		float_request |=> q == hbdd_pkg::Q_OFF)
		else $error("float left a switch on");
	a_kill_all_off: assert property (@(posedge pclk) disable iff (!rst_n)
		kill |=> q == hbdd_pkg::Q_OFF)
		else $error("disable left a switch on");
	a_dead_no_turnon: assert property (@(posedge pclk) disable iff (!rst_n)
		changed |=> (q & ~$past(q)) == hbdd_pkg::Q_OFF)
		else $error("switch on inside dead time");
endmodule // hbdd_bridge
`default_nettype wire

/* File: rtl/hbdd_top.sv */
`timescale 1ns/1ns
`default_nettype none
module hbdd_top #(
	parameter int NUM_CH = 8,
	parameter int ADDR_W = 8
) (
	input wire logic pclk, // apb clock
	input wire logic presetn, // apb reset, low
	input wire logic external_reset_n, // reset pin, low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [ADDR_W-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // apb error
	input wire logic [7:0] channel_control_pin_n, // control pins, low
	input wire logic channel_six_enable_pin, // channel six enable pin
	input wire logic disable_pin, // disable, high
	input wire logic disable_pin_n, // disable, low
	output logic [7:0] gate_on, // switch on command
	output logic [7:0] gate_drive_level, // gate level after polarity
	output logic [7:0] gate_enable // driver not three-stated
);
	logic raw_rst_n;
	logic rst_meta_reg;
	logic core_rst_n;
	logic [31:0] config_reg;
	logic [31:0] channel_reg;
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic [7:0] gate_on_reg;
	logic [7:0] gate_level_reg;
	logic [7:0] gate_enable_reg;
	logic [hbdd_pkg::PINS_W-1:0] pins_raw;
	logic [hbdd_pkg::PINS_W-1:0] pins_sync;
	hbdd_pkg::hbdd_pins_type pins;
	logic kill;
	logic access;
	logic take;
	logic hit_config;
	logic hit_channel;
	logic hit_status;
	logic addr_ok;
	logic [31:0] byte_mask;
	logic [31:0] rd_mux;
	logic [1:0] bridge_select;
	logic [1:0] afw_bits;
	logic [1:0] dead_sel [2];
	logic [3:0] bq [2];
	logic [7:0] highside_fet_type;
	logic [7:0] channel_output_enable;
	logic [7:0] spi_channel_on_cmd;
	logic [7:0] spi_input_sel;
	logic [7:0] on_w;
	logic [7:0] en_w;
	logic [7:0] fet_w;

	if (NUM_CH != 8) begin : g_chk_ch
		$error("hbdd_top serves exactly eight channels");
	end
	if (ADDR_W < 4) begin : g_chk_addr
		$error("hbdd_top needs at least four address bits");
	end

	// ==========================================================
	// reset: either source asserts at once, release is synchronised
	assign raw_rst_n = presetn & external_reset_n;

	always_ff @(posedge pclk or negedge raw_rst_n) begin
		if (!raw_rst_n) begin
			rst_meta_reg <= 1'b0;
			core_rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			core_rst_n <= rst_meta_reg;
		end
	end

	// ==========================================================
	// pin synchroniser
	assign pins_raw = {disable_pin_n, disable_pin, channel_six_enable_pin, channel_control_pin_n};

	hbdd_sync #(
		.W(hbdd_pkg::PINS_W),
		.RESET_VAL(hbdd_pkg::PINS_RESET)
	) u_pin_sync (
		.pclk(pclk),
		.rst_n(core_rst_n),
		.d(pins_raw),
		.q(pins_sync)
	);

	assign pins = pins_sync;
	assign kill = pins.disable_pin | !pins.disable_pin_n;

	// ==========================================================
	// apb slave, one wait state
	assign access = psel && penable;
	assign take = access && pready_reg;
	assign addr_ok = paddr[1:0] == 2'h0;
	assign hit_config = addr_ok && (paddr == ADDR_W'(hbdd_pkg::OFS_CONFIG));
	assign hit_channel = addr_ok && (paddr == ADDR_W'(hbdd_pkg::OFS_CHANNEL));
	assign hit_status = addr_ok && (paddr == ADDR_W'(hbdd_pkg::OFS_STATUS));
	assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_config) begin
			rd_mux = config_reg;
		end else if (hit_channel) begin
			rd_mux = channel_reg;
		end else if (hit_status) begin
			rd_mux[hbdd_pkg::ST_GATE_LSB +: 8] = gate_on_reg;
			rd_mux[hbdd_pkg::ST_PIN_LSB +: hbdd_pkg::PINS_W] = pins_sync;
		end
	end

	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= access && !pready_reg;
		end
	end

	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (access && !pready_reg) begin
			prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_reg <= !(hit_config || hit_channel || hit_status);
		end else begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			config_reg <= hbdd_pkg::CONFIG_RESET;
		end else if (take && pwrite && hit_config) begin
			config_reg <= (config_reg & ~(byte_mask & hbdd_pkg::CONFIG_MASK))
				| (pwdata & byte_mask & hbdd_pkg::CONFIG_MASK);
		end
	end

	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			channel_reg <= hbdd_pkg::CHANNEL_RESET;
		end else if (take && pwrite && hit_channel) begin
			channel_reg <= (channel_reg & ~(byte_mask & hbdd_pkg::CHANNEL_MASK))
				| (pwdata & byte_mask & hbdd_pkg::CHANNEL_MASK);
		end
	end

	// ==========================================================
	// configuration fields
	assign bridge_select = {config_reg[hbdd_pkg::BR2_SEL_BIT], config_reg[hbdd_pkg::BR1_SEL_BIT]};
	assign afw_bits = {config_reg[hbdd_pkg::AFW2_BIT], config_reg[hbdd_pkg::AFW1_BIT]};
	assign dead_sel[0] = config_reg[hbdd_pkg::DT1_LSB +: 2];
	assign dead_sel[1] = config_reg[hbdd_pkg::DT2_LSB +: 2];
	assign highside_fet_type = config_reg[hbdd_pkg::FET_LSB +: 8];
	assign channel_output_enable = config_reg[hbdd_pkg::OUTEN_LSB +: 8];
	assign spi_channel_on_cmd = channel_reg[hbdd_pkg::SPI_ON_LSB +: 8];
	assign spi_input_sel = channel_reg[hbdd_pkg::INSEL_LSB +: 8];

	// ==========================================================
	// bridges, pins of group b: pwm, direction, float, unused
	for (genvar b = 0; b < 2; b++) begin : g_bridge
		hbdd_bridge u_bridge (
			.pclk(pclk),
			.rst_n(core_rst_n),
			.active(bridge_select[b]),
			.kill(kill),
			.afw(afw_bits[b]),
			.dead_sel(dead_sel[b]),
			.pwm_drive_n(pins.channel_control_pin_n[4*b + hbdd_pkg::PIN_PWM]),
			.dir(pins.channel_control_pin_n[4*b + hbdd_pkg::PIN_DIR]),
			.float_request(pins.channel_control_pin_n[4*b + hbdd_pkg::PIN_FLOAT]),
			.q(bq[b])
		);
	end

	// ==========================================================
	// per-channel routing
	for (genvar i = 0; i < 8; i++) begin : g_ch
		localparam int B = i / 4;
		localparam int K = i % 4;
		logic in_bridge;
		logic direct_on;
		logic pin_gate;

		assign in_bridge = bridge_select[B];
		assign direct_on = spi_input_sel[i] ? spi_channel_on_cmd[i] : !pins.channel_control_pin_n[i];
		// bridge channels take their command only from the decoder
		assign on_w[i] = in_bridge ? bq[B][K] : direct_on;
		// roles follow the select bit: first two high side, rest low side
		assign fet_w[i] = in_bridge ? ((K < hbdd_pkg::HS_COUNT) && highside_fet_type[i])
			: highside_fet_type[i];
		assign pin_gate = (i == hbdd_pkg::CH6_INDEX) ? pins.channel_six_enable_pin : 1'b1;
		assign en_w[i] = (in_bridge || channel_output_enable[i]) && pin_gate;
	end

	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			gate_on_reg <= 8'h00;
			gate_level_reg <= 8'h00;
			gate_enable_reg <= 8'h00;
		end else begin
			gate_on_reg <= kill ? 8'h00 : (on_w & en_w);
			gate_level_reg <= (kill ? 8'h00 : (on_w & en_w)) ^ fet_w;
			gate_enable_reg <= en_w;
		end
	end

	assign pready = pready_reg;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;
	assign gate_on = gate_on_reg;
	assign gate_drive_level = gate_level_reg;
	assign gate_enable = gate_enable_reg;

	// ==========================================================
	// checks
	a_ch6_pin_and: assert property (@(posedge pclk) disable iff (!core_rst_n)
		!pins.channel_six_enable_pin |=> !gate_enable[5] && !gate_on[5])
		else $error("channel six on without pin");
	a_spi_ignored: assert property (@(posedge pclk) disable iff (!core_rst_n)
		(bridge_select[0] && !kill && (en_w[3:0] == 4'hf))
		|=> gate_on[3:0] == $past(bq[0]))
		else $error("bridge one not from decoder");
	a_disable_off: assert property (@(posedge pclk) disable iff (!core_rst_n)
		kill |=> gate_on == 8'h00 ##1 gate_on == 8'h00 || !kill)
		else $error("disable left an output on");
	a_polarity_hs: assert property (@(posedge pclk) disable iff (!core_rst_n)
		(bridge_select[1] && !highside_fet_type[4]) |=> gate_drive_level[4] == gate_on[4])
		else $error("nfet high side polarity wrong");

	// bridge two decoder, low sides of both bridges, enable gating
	a_spi_ignored_two: assert property (@(posedge pclk) disable iff (!core_rst_n)
		(bridge_select[1] && !kill && (en_w[7:4] == 4'hf))
		|=> gate_on[7:4] == $past(bq[1]))
		else $error("bridge two not from decoder");
	a_low_side_one: assert property (@(posedge pclk) disable iff (!core_rst_n)
		bridge_select[0] |=> gate_drive_level[3:2] == gate_on[3:2])
		else $error("bridge one low side not nfet");
	a_low_side_two: assert property (@(posedge pclk) disable iff (!core_rst_n)
		bridge_select[1] |=> gate_drive_level[7:6] == gate_on[7:6])
		else $error("bridge two low side not nfet");
	a_gate_needs_en: assert property (@(posedge pclk) disable iff (!core_rst_n)
		(gate_on & ~gate_enable) == 8'h00)
		else $error("gate on while driver disabled");

	// register side
	a_reset_config: assert property (@(posedge pclk) disable iff (!core_rst_n)
		$rose(core_rst_n) |-> config_reg == hbdd_pkg::CONFIG_RESET)
		else $error("config not at reset value");
	a_afw_write: assert property (@(posedge pclk) disable iff (!core_rst_n)
		(take && pwrite && hit_config && (pstrb == 4'hf))
		|=> config_reg == ($past(pwdata) & hbdd_pkg::CONFIG_MASK))
		else $error("config write lost");
	a_ready_pulse: assert property (@(posedge pclk) disable iff (!core_rst_n)
		pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_wait: assert property (@(posedge pclk) disable iff (!core_rst_n)
		(access && !pready) |=> pready)
		else $error("ready not after one wait state");
	a_err_with_ready: assert property (@(posedge pclk) disable iff (!core_rst_n)
		pslverr |-> pready)
		else $error("error without ready");
	a_rdata_idle: assert property (@(posedge pclk) disable iff (!core_rst_n)
		!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside ready");
endmodule // hbdd_top
`default_nettype wire

/* File: test/hbdd_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// host driving the bridge control pins
module hbdd_host_model (
	input wire logic pclk, // clock
	input wire logic [2:0] br1_cmd, // bridge one {float, dir, pwm_n}
	input wire logic [2:0] br2_cmd, // bridge two {float, dir, pwm_n}
	input wire logic en6_req, // hold channel six pin high
	input wire logic dis_req, // assert high disable pin
	input wire logic dis_n_req, // assert low disable pin
	output logic [7:0] channel_control_pin_n, // control pins
	output logic channel_six_enable_pin, // channel six enable pin
	output logic disable_pin, // disable, high
	output logic disable_pin_n // disable, low
);
	logic spare_reg;

	initial begin
		spare_reg = 1'b0;
		channel_control_pin_n = 8'h44;
		channel_six_enable_pin = 1'b1;
		disable_pin = 1'b0;
		disable_pin_n = 1'b1;
	end

	// unused fourth pin toggles so it cannot pass for a held level
	always @(posedge pclk) begin
		spare_reg <= ~spare_reg;
		channel_control_pin_n <= {spare_reg, br2_cmd, ~spare_reg, br1_cmd};
		channel_six_enable_pin <= en6_req;
		disable_pin <= dis_req;
		disable_pin_n <= ~dis_n_req;
	end
endmodule // hbdd_host_model
`default_nettype wire

/* File: test/hbridge_drive_decoder_test.sv */
`timescale 1ns/1ns
`default_nettype none
module hbridge_drive_decoder_test;
	logic pclk, presetn, external_reset_n, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [3:0] pstrb;
	logic pready, pslverr;
	logic [31:0] prdata;
	logic [7:0] gate_on, gate_drive_level, gate_enable, pins_n;
	logic en6_pin, dis_pin, dis_pin_n;
	logic [2:0] br1_cmd, br2_cmd, c2;
	logic en6_req, dis_req, dis_n_req, gate_chk;
	logic [7:0] prev, nq;
	logic [31:0] cfg;
	logic [32:0] apb_q[$];
	logic [23:0] gate_q[$];
	int n_fail, checks_done;

	hbdd_top DUT (.pclk(pclk), .presetn(presetn), .external_reset_n(external_reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.channel_control_pin_n(pins_n), .channel_six_enable_pin(en6_pin),
		.disable_pin(dis_pin), .disable_pin_n(dis_pin_n), .gate_on(gate_on),
		.gate_drive_level(gate_drive_level), .gate_enable(gate_enable));

	hbdd_host_model host (.pclk(pclk), .br1_cmd(br1_cmd), .br2_cmd(br2_cmd),
		.en6_req(en6_req), .dis_req(dis_req), .dis_n_req(dis_n_req),
		.channel_control_pin_n(pins_n), .channel_six_enable_pin(en6_pin),
		.disable_pin(dis_pin), .disable_pin_n(dis_pin_n));

	// ==========================================================
	// helpers
	function automatic logic [3:0] bridge_q(input logic [2:0] c, input logic afw);
		if (c[2]) return 4'h0;
		if (!c[0]) return c[1] ? 4'h9 : 4'h6;
		if (afw) return 4'hc;
		return c[1] ? 4'h8 : 4'h4;
	endfunction

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
		input logic [32:0] exp);
		int n;
		n = 0;
		if (!wr) apb_q.push_back(exp);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			$display("[ERR] %0t no ready", $time);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic expect_gate(input logic [23:0] e);
		gate_q.push_back(e);
		gate_chk <= 1'b1;
		@(posedge pclk);
		gate_chk <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// ==========================================================
	// monitor
	always @(posedge pclk) begin
		if (pready === 1'b1 && pwrite === 1'b0 && apb_q.size() > 0)
			check({pslverr, prdata}, apb_q.pop_front());
		if (gate_chk === 1'b1 && gate_q.size() > 0)
			check({9'h000, gate_enable, gate_drive_level, gate_on}, gate_q.pop_front());
	end

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		$display("[ERR] %0t watchdog", $time);
		report_and_stop();
	end

	// ==========================================================
	// tests
	initial begin
		presetn = 1'b0;
		external_reset_n = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		br1_cmd = 3'b100;
		br2_cmd = 3'b100;
		{en6_req, dis_req, dis_n_req, gate_chk} = 4'b1000;
		n_fail = 0;
		checks_done = 0;
		prev = 8'h00;
		void'($urandom(81));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, 8'h00, 32'h0, {1'b0, 32'h0000_00f0});
		apb(1'b0, 8'h04, 32'h0, 33'h0);
		apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0});
		apb(1'b1, 8'h04, 32'h0000_ffff, 33'h0);
		$display("registers done");
		// both bridges, shortest dead time, p-channel high sides
		for (int a = 0; a < 2; a++) begin
			cfg = a ? 32'h0000_ff0f : 32'h0000_ff03;
			apb(1'b1, 8'h00, cfg, 33'h0);
			apb(1'b0, 8'h00, 32'h0, {1'b0, cfg});
			for (int i = 0; i < 8; i++) begin
				c2 = 3'($urandom_range(7));
				br1_cmd <= i[2:0];
				br2_cmd <= c2;
				nq = {bridge_q(c2, a[0]), bridge_q(i[2:0], a[0])};
				repeat (50) @(posedge pclk);
				expect_gate({8'hff, (prev & nq) ^ 8'h33, prev & nq});
				repeat (65) @(posedge pclk);
				expect_gate({8'hff, nq ^ 8'h33, nq});
				prev = nq;
			end
		end
		$display("truth table done");
		br1_cmd <= 3'b100;
		br2_cmd <= 3'b100;
		en6_req <= 1'b0;
		repeat (10) @(posedge pclk);
		expect_gate({8'hdf, 8'h33, 8'h00});
		en6_req <= 1'b1;
		$display("channel six done");
		for (int k = 0; k < 2; k++) begin
			br1_cmd <= 3'b010;
			repeat (115) @(posedge pclk);
			expect_gate({8'hff, 8'h3a, 8'h09});
			dis_req <= (k == 0);
			dis_n_req <= (k == 1);
			repeat (8) @(posedge pclk);
			expect_gate({8'hff, 8'h33, 8'h00});
			dis_req <= 1'b0;
			dis_n_req <= 1'b0;
		end
		repeat (115) @(posedge pclk);
		expect_gate({8'hff, 8'h3a, 8'h09});
		$display("disable done");
		external_reset_n <= 1'b0;
		repeat (2) @(posedge pclk);
		expect_gate(24'h0);
		external_reset_n <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, 8'h00, 32'h0, {1'b0, 32'h0000_00f0});
		$display("reset done");
		report_and_stop();
	end
endmodule // hbridge_drive_decoder_test
`default_nettype wire
